// ### tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Register word offsets.
`define TCC_OFF_IRQ_VECTOR 16'h012E
`define TCC_OFF_TCTL       16'h0160
`define TCC_OFF_C0CTL      16'h0162
`define TCC_OFF_C1CTL      16'h0164
`define TCC_OFF_COUNT      16'h0170
`define TCC_OFF_C0VAL      16'h0172
`define TCC_OFF_C1VAL      16'h0174
// Timer control fields.
`define TCC_TC_IFG    0
`define TCC_TC_IE     1
`define TCC_TC_CLR    2
`define TCC_TC_MC_LO  4
`define TCC_TC_SSEL_LO 8
// Channel control fields.
`define TCC_CC_IFG    0
`define TCC_CC_OUT    2
`define TCC_CC_CCI    3
`define TCC_CC_IE     4
`define TCC_CC_OM_LO  5
`define TCC_CC_CAP    8
`define TCC_CC_IS_LO  12
`define TCC_CC_CM_LO  14
// Reset values.
`define TCC_RST_WORD  16'h0000
// Interrupt vector codes.
`define TCC_IV_NONE   16'h0000
`define TCC_IV_CH1    16'h0002
`define TCC_IV_OVF    16'h000A
`endif

// ### tcc_pkg.sv
package tcc_pkg;
  // Counter modes.
  typedef enum logic [1:0] {tcc_stop, tcc_up, tcc_cont, tcc_updown} tcc_mode_type;
endpackage

// ### tcc_channel.sv
`timescale 1ns/10ps
`include "tcc_map.svh"
// One capture/compare channel: input select, edge detect, match, output unit.
module tcc_channel #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [1:0]       in_sel,
  input  wire logic [1:0]       cap_mode,
  input  wire logic             cap_en,
  input  wire logic [2:0]       out_mode,
  input  wire logic             out_bit,
  input  wire logic             in_a,
  input  wire logic             in_b,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0] value,
  input  wire logic             period_hit,
  input  wire logic             tick,
  output logic                  cci,
  output logic                  capture,
  output logic                  match,
  output logic                  sig
);
  // Selected input: pin, internal source, ground, supply.
  wire sel_in = (in_sel == 2'h0) ? in_a : (in_sel == 2'h1) ? in_b : in_sel[0]; // R05 R06
  logic prev;  // Previous sampled input.
  wire rise = sel_in & ~prev;
  wire fall = ~sel_in & prev;
  // Capture event on chosen edges.
  assign capture = cap_en & ((cap_mode[0] & rise) | (cap_mode[1] & fall)); // R11
  // Compare match while the counter advances.
  assign match = ~cap_en & tick & (count == value); // R11
  assign cci = prev;
  // Edge history register.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= sel_in;
    end
  end
  // Output unit: set, toggle, reset and PWM modes on match and period.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sig <= 1'b0;
    end else if (ce) begin
      unique case (out_mode)
        3'h0: sig <= out_bit;                                          // R12
        3'h1: sig <= match ? 1'b1 : sig;
        3'h2: sig <= match ? ~sig : (period_hit ? 1'b0 : sig);         // R02
        3'h3: sig <= match ? 1'b1 : (period_hit ? 1'b0 : sig);
        3'h4: sig <= match ? ~sig : sig;
        3'h5: sig <= match ? 1'b0 : sig;
        3'h6: sig <= match ? ~sig : (period_hit ? 1'b1 : sig);
        3'h7: sig <= match ? 1'b0 : (period_hit ? 1'b1 : sig);         // R02
      endcase
    end
  end
endmodule // tcc_channel

// ### tcc_timer.sv
`timescale 1ns/10ps
`include "tcc_map.svh"
// What this block does
// (R01) 16-bit counter shared by two channels.
// (R02) Capture, PWM output and interval timing.
// (R03) Interrupts on overflow and each channel.
// (R04) Counter clock from four selectable sources.
// (R05) Channel 0 input: pin, aux clock, ground, supply.
// (R06) Channel 1 input B is comparator output.
// (R07) Counter and channel values at 0170h-0174h.
// (R08) Control registers at 0160h, 0162h, 0164h.
// (R09) Vector register at 012Eh names pending source.
// (R10) Software uses 16-bit word accesses only.
// (R11) Capture copies counter; compare flags equality.
// (R12) Channel signals drive their output pins.
module tcc_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [15:0]      addr,
  input  wire logic [15:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [15:0]      rdata,
  input  wire logic             ext_counter_clock_pin,
  input  wire logic             aux_clock,
  input  wire logic             submain_clock,
  input  wire logic             chan0_capture_in_a,
  input  wire logic             chan1_capture_in_a,
  input  wire logic             comparator_output,
  output logic                  chan0_signal,
  output logic                  chan1_signal,
  output logic                  irq_chan0,
  output logic                  irq_other
);
  // Refuse at elaboration any counter width other than the one the logic is built for.
  if (WIDTH != 16) begin : g_width_check
    $error("tcc_timer supports only a 16-bit counter");
  end
  logic [15:0] timer_control;  // Clock select, mode, enable and flag.
  logic [15:0] chan_ctl [2];   // Channel control words.
  logic [15:0] chan_val [2];   // Channel value words.
  logic [15:0] counter_value;  // Shared counter.
  logic        clk_prev;       // Previous selected clock level.
  logic        dir_down;       // Up/down counting direction.
  tcc_pkg::tcc_mode_type mode;
  assign mode = tcc_pkg::tcc_mode_type'(timer_control[`TCC_TC_MC_LO +: 2]);
  // Counter clock select; the alternate input is the same pin inverted.
  wire [1:0] ssel = timer_control[`TCC_TC_SSEL_LO +: 2];
  wire clk_sel = (ssel == 2'h0) ? ext_counter_clock_pin :
                 (ssel == 2'h1) ? aux_clock :
                 (ssel == 2'h2) ? submain_clock : ~ext_counter_clock_pin; // R04
  // A count step happens on each rising edge of the chosen source unless the mode is stop.
  wire tick = ce & clk_sel & ~clk_prev & (mode != tcc_pkg::tcc_stop);
  wire [15:0] top = (mode == tcc_pkg::tcc_cont) ? 16'hFFFF : chan_val[0];
  wire at_top = (counter_value == top);
  wire at_zero = (counter_value == 16'h0000);
  // Overflow when the counter wraps to zero or turns at zero going down.
  wire ovf = tick & (((mode != tcc_pkg::tcc_updown) & at_top) |
                     (dir_down & (counter_value == 16'h0001)));
  wire [15:0] next_counter = (mode == tcc_pkg::tcc_updown) ?
    ((dir_down | at_top) ? counter_value - 16'h0001 : counter_value + 16'h0001) :
    (at_top ? 16'h0000 : counter_value + 16'h0001); // R01 R02
  wire next_dir = (mode == tcc_pkg::tcc_updown) &
                  ((at_top & ~at_zero) | (dir_down & (counter_value != 16'h0001)));
  // Word-wide register decode.
  wire wr_tctl  = ce & wr & (addr == `TCC_OFF_TCTL);   // R08 R10
  wire wr_c0ctl = ce & wr & (addr == `TCC_OFF_C0CTL);  // R08
  wire wr_c1ctl = ce & wr & (addr == `TCC_OFF_C1CTL);  // R08
  wire wr_cnt   = ce & wr & (addr == `TCC_OFF_COUNT);  // R07
  wire wr_c0val = ce & wr & (addr == `TCC_OFF_C0VAL);  // R07
  wire wr_c1val = ce & wr & (addr == `TCC_OFF_C1VAL);  // R07
  wire rd_iv    = ce & rd & (addr == `TCC_OFF_IRQ_VECTOR); // R09
  wire [1:0] ch_cap, ch_match, ch_cci, ch_sig;
  // Pending vector: channel 1 ahead of overflow.
  wire pend1 = chan_ctl[1][`TCC_CC_IFG] & chan_ctl[1][`TCC_CC_IE];
  wire pendo = timer_control[`TCC_TC_IFG] & timer_control[`TCC_TC_IE];
  wire [15:0] vec = pend1 ? `TCC_IV_CH1 : (pendo ? `TCC_IV_OVF : `TCC_IV_NONE); // R09
  // Channel instances; channel 1 input B is the comparator.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire [15:0] c = chan_ctl[g];
      tcc_channel #(.WIDTH(WIDTH)) u_ch (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .ce         (ce),
        .in_sel     (c[`TCC_CC_IS_LO +: 2]),
        .cap_mode   (c[`TCC_CC_CM_LO +: 2]),
        .cap_en     (c[`TCC_CC_CAP]),
        .out_mode   (c[`TCC_CC_OM_LO +: 3]),
        .out_bit    (c[`TCC_CC_OUT]),
        .in_a       (g == 0 ? chan0_capture_in_a : chan1_capture_in_a),
        .in_b       (g == 0 ? aux_clock : comparator_output), // R05 R06
        .count      (counter_value),
        .value      (chan_val[g]),
        .period_hit (tick & at_zero),
        .tick       (tick),
        .cci        (ch_cci[g]),
        .capture    (ch_cap[g]),
        .match      (ch_match[g]),
        .sig        (ch_sig[g])
      );
      // Control word: the event sets the flag, winning over a clear.
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          chan_ctl[g] <= `TCC_RST_WORD;
        end else if (ce) begin
          if ((g == 0) ? wr_c0ctl : wr_c1ctl) begin
            chan_ctl[g] <= wdata;
          end else begin
            chan_ctl[g][`TCC_CC_CCI] <= ch_cci[g];
          end
          if (ch_cap[g] | ch_match[g]) begin
            chan_ctl[g][`TCC_CC_IFG] <= 1'b1; // R03
          end else if ((g == 1) & rd_iv & pend1) begin
            chan_ctl[g][`TCC_CC_IFG] <= 1'b0; // R09
          end
        end
      end
      // Value word: software write or capture of the counter.
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          chan_val[g] <= `TCC_RST_WORD;
        end else if (ce) begin
          if (ch_cap[g]) begin
            chan_val[g] <= counter_value; // R11
          end else if ((g == 0) ? wr_c0val : wr_c1val) begin
            chan_val[g] <= wdata;
          end
        end
      end
    end
  endgenerate
  // Timer control word with clear bit and overflow flag.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer_control <= `TCC_RST_WORD;
    end else if (ce) begin
      if (wr_tctl) begin
        timer_control <= wdata & ~(16'h0001 << `TCC_TC_CLR);
      end
      if (ovf) begin
        timer_control[`TCC_TC_IFG] <= 1'b1; // R03
      end else if (rd_iv & ~pend1 & pendo) begin
        timer_control[`TCC_TC_IFG] <= 1'b0; // R09
      end
    end
  end
  // Counter, direction and clock edge history.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      counter_value <= `TCC_RST_WORD;
      dir_down      <= 1'b0;
      clk_prev      <= 1'b0;
    end else if (ce) begin
      clk_prev <= clk_sel;
      if (wr_tctl & wdata[`TCC_TC_CLR]) begin
        counter_value <= `TCC_RST_WORD;
        dir_down      <= 1'b0;
      end else if (wr_cnt) begin
        counter_value <= wdata;
      end else if (tick) begin
        counter_value <= next_counter; // R01
        dir_down      <= next_dir;
      end
    end
  end
  // Read data mux.
  wire [15:0] rmux =
    (addr == `TCC_OFF_TCTL)  ? timer_control :
    (addr == `TCC_OFF_C0CTL) ? chan_ctl[0] :
    (addr == `TCC_OFF_C1CTL) ? chan_ctl[1] :
    (addr == `TCC_OFF_COUNT) ? counter_value :
    (addr == `TCC_OFF_C0VAL) ? chan_val[0] :
    (addr == `TCC_OFF_C1VAL) ? chan_val[1] :
    (addr == `TCC_OFF_IRQ_VECTOR) ? vec : 16'h0000; // R07 R08 R09
  // Registered outputs.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata        <= 16'h0000;
      chan0_signal <= 1'b0;
      chan1_signal <= 1'b0;
      irq_chan0    <= 1'b0;
      irq_other    <= 1'b0;
    end else if (ce) begin
      rdata        <= rd ? rmux : 16'h0000;
      chan0_signal <= ch_sig[0]; // R12
      chan1_signal <= ch_sig[1]; // R12
      irq_chan0    <= chan_ctl[0][`TCC_CC_IFG] & chan_ctl[0][`TCC_CC_IE]; // R03
      irq_other    <= pend1 | pendo; // R03
    end
  end
  property p_ovf_flag;
    @(posedge sys_clk) disable iff (!rstn) ovf |=> timer_control[`TCC_TC_IFG];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // R03
  property p_capture;
    @(posedge sys_clk) disable iff (!rstn)
      ce && ch_cap[0] |=> chan_val[0] == $past(counter_value);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // R11
  property p_irq0;
    @(posedge sys_clk) disable iff (!rstn)
      ce && chan_ctl[0][`TCC_CC_IFG] && chan_ctl[0][`TCC_CC_IE] |=> irq_chan0;
  endproperty
  a_irq0: assert property (p_irq0) else $error("channel 0 irq missing"); // R03
  property p_count;
    @(posedge sys_clk) disable iff (!rstn)
      tick && !wr && mode == tcc_pkg::tcc_cont |=> counter_value == $past(counter_value) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step"); // R01
  property p_vec;
    @(posedge sys_clk) disable iff (!rstn) rd_iv && pend1 |=> rdata == `TCC_IV_CH1;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong"); // R09
  // Stop mode with no software write, then one more cycle with no software write.
  sequence s_stopped_quiet;
    mode == tcc_pkg::tcc_stop && !wr ##1 !wr;
  endsequence
  property p_stop;
    @(posedge sys_clk) disable iff (!rstn) s_stopped_quiet |-> $stable(counter_value);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped"); // R02
  property p_match;
    @(posedge sys_clk) disable iff (!rstn) ch_match[1] |=> chan_ctl[1][`TCC_CC_IFG];
  endproperty
  a_match: assert property (p_match) else $error("compare flag missing"); // R11
  property p_sig;
    @(posedge sys_clk) disable iff (!rstn) ce |=> chan1_signal == $past(ch_sig[1]);
  endproperty
  a_sig: assert property (p_sig) else $error("output pin not following"); // R12
endmodule // tcc_timer

// ### tcc_far_side.sv
`timescale 1ns/10ps
// Far side of the timer: clock sources, capture pins and comparator output.
module tcc_far_side (
  input  wire logic sys_clk,
  output logic      ext_counter_clock_pin,
  output logic      aux_clock,
  output logic      submain_clock,
  output logic      chan0_capture_in_a,
  output logic      chan1_capture_in_a,
  output logic      comparator_output
);
  // Every source starts low, so no stray edge shows after reset.
  initial begin
    {ext_counter_clock_pin, aux_clock, submain_clock} = 3'h0;
    {chan0_capture_in_a, chan1_capture_in_a, comparator_output} = 3'h0;
  end
  // Sets one source: 0 and 3 pin, 1 aux, 2 submain, 4 ch0 pin, 5 ch1 pin, else comparator.
  task automatic drive(input int src, input logic lvl);
    case (src)
      0, 3: ext_counter_clock_pin <= lvl;
      1: aux_clock <= lvl;
      2: submain_clock <= lvl;
      4: chan0_capture_in_a <= lvl;
      5: chan1_capture_in_a <= lvl;
      default: comparator_output <= lvl;
    endcase
  endtask
  // Sends n whole pulses; each level stands two cycles so the sampler sees it.
  task automatic pulse(input int src, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      drive(src, 1'b1);
      repeat (2) @(posedge sys_clk);
      drive(src, 1'b0);
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule // tcc_far_side

// ### timer_capture_compare_2ch_bench.sv
`timescale 1ns/10ps
// Self-checking bench: reads are noted in a queue and judged by a monitor.
module timer_capture_compare_2ch_bench;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        ce      = 1'b1;
  logic [15:0] addr    = 16'h0000;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        rd_d    = 1'b0;
  logic [15:0] rdata;
  logic        ext_pin, aux_clk, sub_clk, cap0, cap1, cmp_out;
  logic        chan0_signal, chan1_signal, irq_chan0, irq_other;
  logic [15:0] exp_q [$];
  logic [15:0] v0;
  logic [15:0] addrs [8] = '{16'h012E, 16'h0160, 16'h0162, 16'h0164,
                             16'h0170, 16'h0172, 16'h0174, 16'h0166};
  int          err_total = 0;
  int          samples_checked = 0;
  int          seed = 79;
  int          n;
  // The clock runs at 40 MHz.
  always #12.5 sys_clk = ~sys_clk;
  tcc_timer u_tcc_timer (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_counter_clock_pin(ext_pin),
    .aux_clock(aux_clk), .submain_clock(sub_clk), .chan0_capture_in_a(cap0),
    .chan1_capture_in_a(cap1), .comparator_output(cmp_out), .chan0_signal(chan0_signal),
    .chan1_signal(chan1_signal), .irq_chan0(irq_chan0), .irq_other(irq_other));
  tcc_far_side u_tcc_far_side (.sys_clk(sys_clk), .ext_counter_clock_pin(ext_pin),
    .aux_clock(aux_clk), .submain_clock(sub_clk), .chan0_capture_in_a(cap0),
    .chan1_capture_in_a(cap1), .comparator_output(cmp_out));
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One word write, held until the taking edge.
  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // One word read; the expected word is noted for the monitor.
  task automatic rreg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    {addr, rd} <= {a, 1'b1};
    exp_q.push_back(exp);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask
  // Selects a clock source with the counter stopped and cleared, then runs it.
  task automatic cfg(input logic [1:0] s);
    wreg(16'h0160, {6'h00, s, 8'h04});
    wreg(16'h0160, {6'h00, s, 8'h20});
  endtask
  // Ends the run with the counts and the verdict.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Read data stands the cycle after the taking edge; it is judged mid-cycle.
  always @(posedge sys_clk) rd_d <= rd & ce;
  always @(negedge sys_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      check("rdata", rdata, exp_q.pop_front());
    end
  end
  // Cuts a hang short long after the tests should have finished.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (addrs[i]) rreg(addrs[i], 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v0 = 16'($random(seed));
      wreg(16'h0172, v0);
      rreg(16'h0172, v0);
      wreg(16'h0174, ~v0);
      rreg(16'h0174, ~v0);
    end
    // A write while the clock enable is low must be ignored.
    ce <= 1'b0;
    wreg(16'h0172, ~v0);
    ce <= 1'b1;
    rreg(16'h0172, v0);
    $display("test value registers done");
    for (int s = 0; s < 4; s++) begin
      cfg(s[1:0]);
      n = ($random(seed) & 7) + 1;
      u_tcc_far_side.pulse(s, n);
      repeat (4) @(posedge sys_clk);
      rreg(16'h0170, n[15:0]);
    end
    cfg(2'h1);
    u_tcc_far_side.pulse(1, 5);
    $display("test clock sources done");
    wreg(16'h0162, 16'h4110);
    u_tcc_far_side.pulse(4, 1);
    rreg(16'h0172, 16'h0005);
    check("irq_chan0", irq_chan0, 1'b1);
    wreg(16'h0162, 16'h0000);
    repeat (2) @(posedge sys_clk);
    check("irq_chan0", irq_chan0, 1'b0);
    wreg(16'h0164, 16'h5110);
    u_tcc_far_side.pulse(6, 1);
    rreg(16'h0174, 16'h0005);
    check("irq_other", irq_other, 1'b1);
    rreg(16'h012E, 16'h0002);
    repeat (2) @(posedge sys_clk);
    check("irq_other", irq_other, 1'b0);
    $display("test capture done");
    wreg(16'h0164, 16'h0010);
    wreg(16'h0174, 16'h0008);
    u_tcc_far_side.pulse(1, 4);
    check("irq_other", irq_other, 1'b1);
    rreg(16'h012E, 16'h0002);
    wreg(16'h0162, 16'h0004);
    repeat (3) @(posedge sys_clk);
    check("chan0_signal", chan0_signal, 1'b1);
    $display("test compare done");
    wreg(16'h0160, 16'h0122);
    wreg(16'h0170, 16'hFFFE);
    u_tcc_far_side.pulse(1, 2);
    check("irq_other", irq_other, 1'b1);
    rreg(16'h012E, 16'h000A);
    rreg(16'h0170, 16'h0000);
    repeat (3) @(posedge sys_clk);
    check("irq_other", irq_other, 1'b0);
    $display("test overflow done");
    // Up mode with period 3 and channel 1 in reset/set output mode at value 2.
    wreg(16'h0164, 16'h00E0);
    wreg(16'h0174, 16'h0002);
    wreg(16'h0172, 16'h0003);
    wreg(16'h0160, 16'h0116);
    u_tcc_far_side.pulse(1, 1);
    check("chan1_signal", chan1_signal, 1'b1);
    u_tcc_far_side.pulse(1, 2);
    check("chan1_signal", chan1_signal, 1'b0);
    u_tcc_far_side.pulse(1, 2);
    check("chan1_signal", chan1_signal, 1'b1);
    rreg(16'h0170, 16'h0001);
    rreg(16'h012E, 16'h000A);
    // Up/down mode turns at the period and overflows only on reaching zero.
    wreg(16'h0160, 16'h0136);
    u_tcc_far_side.pulse(1, 5);
    rreg(16'h0170, 16'h0001);
    rreg(16'h012E, 16'h0000);
    u_tcc_far_side.pulse(1, 1);
    rreg(16'h012E, 16'h000A);
    // Supply then ground as channel 0 input give a rising then a falling capture.
    wreg(16'h0162, 16'h7100);
    repeat (2) @(posedge sys_clk);
    rreg(16'h0162, 16'h7109);
    wreg(16'h0162, 16'hA100);
    repeat (2) @(posedge sys_clk);
    rreg(16'h0162, 16'hA101);
    $display("test modes done");
    // A reset in mid-run returns the control words to zero.
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rreg(16'h0160, 16'h0000);
    rreg(16'h0162, 16'h0000);
    $display("test second reset done");
    end_of_test();
  end
endmodule // timer_capture_compare_2ch_bench
